// ### design/gpioc_top.sv
// Dual-port GPIO with change-detect flag behind an Avalon-MM slave.
`timescale 1ns/1ps
module gpioc_top #(
   parameter int PA_W = 5,
   parameter int PB_W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire gpioc_pkg::gpioc_req_s avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [PA_W-1:0] pa_in,
   output logic [PA_W-1:0] pa_out,
   output logic [PA_W-1:0] pa_oe,
   output logic [3:0] analog_sel,
   output logic timer_clk_in,
   input wire logic [PB_W-1:0] pb_in,
   output logic [PB_W-1:0] pb_out,
   output logic [PB_W-1:0] pb_oe,
   output logic [PB_W-1:0] pb_pullup_en,
   input wire logic [PB_W-1:0] periph_own,
   input wire logic [PB_W-1:0] periph_dir,
   input wire logic [PB_W-1:0] periph_out,
   output logic port_change_flag,
   output logic wake_req
);
   import gpioc_pkg::*;

   // Decodes the analog pin-select field: lower pins are analog unless set digital.
   function automatic logic [3:0] analog_mask(input logic [7:0] cfg);
      analog_mask = (cfg[2:1] == GPIOC_ACFG_DIGITAL) ? 4'h0 : 4'hF;
   endfunction

   gpioc_bus_e bus_q;
   gpioc_bus_e bus_d;
   logic [7:0] pa_latch_q;
   logic [7:0] pa_dir_q;
   logic [7:0] acfg_q;
   logic [7:0] pb_latch_q;
   logic [7:0] pb_dir_q;
   logic [7:0] opt_q;
   logic [7:0] ictl_q;
   logic [3:0] ref_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [PA_W-1:0] pa_out_q;
   logic [PA_W-1:0] pa_oe_q;
   logic [3:0] asel_q;
   logic tclk_q;
   logic [PB_W-1:0] pb_out_q;
   logic [PB_W-1:0] pb_oe_q;
   logic [PB_W-1:0] pb_pu_q;
   logic flag_q;
   logic flag_d;
   logic wake_q;
   // Waitrequest has its own flop so the bus never sees a decode glitch on it.
   logic wait_q;
   wire [PA_W-1:0] pa_oe_d;
   wire [PA_W-1:0] pa_out_d;
   wire [PB_W-1:0] pb_oe_d;
   wire [PB_W-1:0] pb_out_d;
   wire [PB_W-1:0] pb_pu_d;

   wire req = avs_req.read | avs_req.write;
   wire finish = req & (bus_q == GPIOC_DONE);
   wire wr_done = finish & avs_req.write & avs_req.byteenable[0];
   wire rd_done = finish & avs_req.read;
   wire [4:0] addr = avs_req.address;
   wire [7:0] wbyte = avs_req.writedata[7:0];
   // A set upper lane narrows the write to the masked bits; others keep pin levels.
   wire [7:0] wmask = avs_req.byteenable[1] ? avs_req.writedata[15:8] : 8'hFF;
   wire [3:0] amask = analog_mask(acfg_q);
   // Analog-selected pins read back as zero on the digital path.
   wire [7:0] pa_pins = {3'h0, pa_in[4], pa_in[3:0] & ~amask};
   wire [7:0] pb_pins = pb_in;
   wire [7:0] pb_eff_dir = (periph_own & periph_dir) | (~periph_own & pb_dir_q);
   wire [7:0] pb_eff_out = (periph_own & periph_out) | (~periph_own & pb_latch_q);
   wire [3:0] watched = pb_eff_dir[7:4];
   wire mismatch = |((pb_pins[7:4] ^ ref_q) & watched);
   wire sel_pa = addr == GPIOC_OFF_PA;
   wire sel_pa_dir = addr == GPIOC_OFF_PA_DIR;
   wire sel_acfg = addr == GPIOC_OFF_ACFG;
   wire sel_pb = addr == GPIOC_OFF_PB;
   wire sel_pb_dir = addr == GPIOC_OFF_PB_DIR;
   wire sel_opt = addr == GPIOC_OFF_OPT;
   wire sel_ictl = addr == GPIOC_OFF_ICTL;
   wire flag_clr = wr_done & sel_ictl & ~wbyte[GPIOC_FLAG_BIT];
   wire [7:0] pa_rmw = (pa_pins & ~wmask) | (wbyte & wmask);
   wire [7:0] pb_rmw = (pb_pins & ~wmask) | (wbyte & wmask);

   assign bus_d = (req & (bus_q == GPIOC_IDLE)) ? GPIOC_DONE : GPIOC_IDLE;
   // The flag is sticky and a live mismatch outranks a clear in the same cycle.
   assign flag_d = mismatch | (flag_q & ~flag_clr);

   always_comb
   begin
      case (addr)
         GPIOC_OFF_PA: rdata_d = {24'h0, pa_pins & GPIOC_PA_MASK};
         GPIOC_OFF_PA_DIR: rdata_d = {24'h0, pa_dir_q & GPIOC_PA_MASK};
         GPIOC_OFF_ACFG: rdata_d = {24'h0, acfg_q & GPIOC_ACFG_MASK};
         GPIOC_OFF_PB: rdata_d = {24'h0, pb_pins};
         GPIOC_OFF_PB_DIR: rdata_d = {24'h0, pb_dir_q};
         GPIOC_OFF_OPT: rdata_d = {24'h0, opt_q};
         GPIOC_OFF_ICTL: rdata_d = {24'h0, ictl_q[7:1], flag_q};
         default: rdata_d = GPIOC_UNMAPPED;
      endcase
   end

   // Data is registered on the same edge that waitrequest drops, so it stands at the taking edge.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bus_q <= GPIOC_IDLE;
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         bus_q <= bus_d;
         wait_q <= (bus_d != GPIOC_DONE);
         if (req && bus_q == GPIOC_IDLE)
         begin
            rdata_q <= rdata_d;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pa_latch_q <= GPIOC_RST_PA;
         pa_dir_q <= GPIOC_RST_PA_DIR;
         acfg_q <= GPIOC_RST_ACFG;
      end
      else if (wr_done)
      begin
         if (sel_pa)
         begin
            pa_latch_q <= pa_rmw & GPIOC_PA_MASK;
         end
         if (sel_pa_dir)
         begin
            pa_dir_q <= wbyte & GPIOC_PA_MASK;
         end
         if (sel_acfg)
         begin
            acfg_q <= wbyte & GPIOC_ACFG_MASK;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pb_latch_q <= GPIOC_RST_PB;
         pb_dir_q <= GPIOC_RST_PB_DIR;
         opt_q <= GPIOC_RST_OPT;
         ictl_q <= GPIOC_RST_ICTL;
      end
      else if (wr_done)
      begin
         if (sel_pb)
         begin
            pb_latch_q <= pb_rmw;
         end
         if (sel_pb_dir)
         begin
            pb_dir_q <= wbyte;
         end
         if (sel_opt)
         begin
            opt_q <= wbyte;
         end
         if (sel_ictl)
         begin
            ictl_q <= wbyte & GPIOC_ICTL_MASK;
         end
      end
   end

   // Every completed read of the second port refreshes the reference, which ends
   // the mismatch so that a clear can drop the sticky flag.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ref_q <= 4'h0;
         flag_q <= 1'b0;
         wake_q <= 1'b0;
      end
      else
      begin
         if (rd_done && sel_pb)
         begin
            ref_q <= pb_pins[7:4];
         end
         flag_q <= flag_d;
         wake_q <= flag_d & ictl_q[GPIOC_CHG_EN_BIT];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_pa_low
         assign pa_oe_d[gi] = ~pa_dir_q[gi];
         assign pa_out_d[gi] = pa_latch_q[gi];
      end
      for (gi = 0; gi < PB_W; gi++)
      begin : g_pb
         assign pb_oe_d[gi] = ~pb_eff_dir[gi];
         assign pb_out_d[gi] = pb_eff_out[gi];
         assign pb_pu_d[gi] = ~opt_q[GPIOC_PULLUP_N_BIT] & pb_eff_dir[gi];
      end
   endgenerate

   // The shared pin can only pull low; a latch one releases it to the pull-up.
   assign pa_oe_d[GPIOC_OD_BIT] = ~pa_dir_q[GPIOC_OD_BIT] & ~pa_latch_q[GPIOC_OD_BIT];
   assign pa_out_d[GPIOC_OD_BIT] = 1'b0;

   // One process owns every pin-side flop, so no vector has more than one writer.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pa_oe_q <= {PA_W{1'b0}};
         pa_out_q <= {PA_W{1'b0}};
         asel_q <= 4'hF;
         tclk_q <= 1'b0;
         pb_oe_q <= {PB_W{1'b0}};
         pb_out_q <= {PB_W{1'b0}};
         pb_pu_q <= {PB_W{1'b0}};
      end
      else
      begin
         pa_oe_q <= pa_oe_d;
         pa_out_q <= pa_out_d;
         asel_q <= amask;
         tclk_q <= pa_in[GPIOC_OD_BIT];
         pb_oe_q <= pb_oe_d;
         pb_out_q <= pb_out_d;
         pb_pu_q <= pb_pu_d;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign pa_out = pa_out_q;
   assign pa_oe = pa_oe_q;
   assign analog_sel = asel_q;
   assign timer_clk_in = tclk_q;
   assign pb_out = pb_out_q;
   assign pb_oe = pb_oe_q;
   assign pb_pullup_en = pb_pu_q;
   assign port_change_flag = flag_q;
   assign wake_req = wake_q;

   flag_set_a: assert property (@(posedge clk) disable iff (!resetn)
      mismatch |=> port_change_flag)
      else $error("mismatch did not set the change flag");

   flag_sticky_a: assert property (@(posedge clk) disable iff (!resetn)
      (port_change_flag && !flag_clr) |=> port_change_flag)
      else $error("change flag dropped without a clear");

   flag_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      (flag_clr && !mismatch) |=> !port_change_flag)
      else $error("change flag not cleared");

   ref_capture_a: assert property (@(posedge clk) disable iff (!resetn)
      (rd_done && sel_pb) |=> ref_q == $past(pb_in[7:4]))
      else $error("reference not captured on second port read");

   bus_answer_a: assert property (@(posedge clk) disable iff (!resetn)
      (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not exactly one cycle after request");

   od_pin_a: assert property (@(posedge clk) disable iff (!resetn)
      !pa_out[GPIOC_OD_BIT])
      else $error("open-drain pin driven high");

   pa_drive_a: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> pa_oe[3:0] == ~$past(pa_dir_q[3:0]) && pa_out[3:0] == $past(pa_latch_q[3:0]))
      else $error("first port drive does not follow direction");

   pullup_off_a: assert property (@(posedge clk) disable iff (!resetn)
      (pb_oe & pb_pullup_en) == 8'h00)
      else $error("pull-up on while pin drives");

   upper_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      (rd_done && (sel_pa || sel_pa_dir || sel_acfg)) |-> avs_readdata[7:5] == 3'h0)
      else $error("unimplemented bits read nonzero");

   wake_a: assert property (@(posedge clk) disable iff (!resetn)
      (mismatch && ictl_q[GPIOC_CHG_EN_BIT]) |=> wake_req)
      else $error("enabled change did not raise wake");

   // Checks that start from reset use resetn as antecedent, so the release edge is skipped.
   pullup_en_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> pb_pullup_en == ({8{~$past(opt_q[GPIOC_PULLUP_N_BIT])}} & ~pb_oe))
      else $error("pull-ups do not follow the global control");

   analog_sel_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> analog_sel == (($past(acfg_q[2:1]) == GPIOC_ACFG_DIGITAL) ? 4'h0 : 4'hF))
      else $error("analog select does not follow the pin configuration");

   od_release_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> pa_oe[GPIOC_OD_BIT]
         == !($past(pa_dir_q[GPIOC_OD_BIT]) || $past(pa_latch_q[GPIOC_OD_BIT])))
      else $error("open-drain pin enable does not follow direction and latch");

   pb_drive_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> pb_oe == ~$past(pb_eff_dir) && pb_out == $past(pb_eff_out))
      else $error("second port drive does not follow direction or override");

   no_false_set_a: assert property (@(posedge clk) disable iff (!resetn)
      (!port_change_flag && !mismatch) |=> !port_change_flag)
      else $error("change flag set without a watched mismatch");

   pb_latch_a: assert property (@(posedge clk) disable iff (!resetn)
      (wr_done && sel_pb && !avs_req.byteenable[1]) |=> pb_latch_q == $past(wbyte))
      else $error("second port latch did not take the written byte");

   pa_latch_a: assert property (@(posedge clk) disable iff (!resetn)
      (wr_done && sel_pa && !avs_req.byteenable[1])
         |=> pa_latch_q == ($past(wbyte) & GPIOC_PA_MASK))
      else $error("first port latch did not take the masked byte");

   timer_clk_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> timer_clk_in == $past(pa_in[GPIOC_OD_BIT]))
      else $error("timer clock does not follow the shared pin");

   ref_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      !(rd_done && sel_pb) |=> $stable(ref_q))
      else $error("reference changed without a second port read");

   wake_off_a: assert property (@(posedge clk) disable iff (!resetn)
      !ictl_q[GPIOC_CHG_EN_BIT] |=> !wake_req)
      else $error("wake raised while change wake is disabled");

   dir_write_a: assert property (@(posedge clk) disable iff (!resetn)
      (wr_done && sel_pa_dir) |=> pa_dir_q == ($past(wbyte) & GPIOC_PA_MASK))
      else $error("first port direction write not masked");

   acfg_write_a: assert property (@(posedge clk) disable iff (!resetn)
      (wr_done && sel_acfg) |=> acfg_q == ($past(wbyte) & GPIOC_ACFG_MASK))
      else $error("analog configuration write not masked");

   flag_read_a: assert property (@(posedge clk) disable iff (!resetn)
      (rd_done && sel_ictl) |-> avs_readdata[GPIOC_FLAG_BIT] == $past(port_change_flag))
      else $error("control read does not show the change flag");

   pb_read_a: assert property (@(posedge clk) disable iff (!resetn)
      (rd_done && sel_pb) |-> avs_readdata[7:0] == $past(pb_in))
      else $error("second port read does not return the pin levels");

   pa_read_a: assert property (@(posedge clk) disable iff (!resetn)
      (rd_done && sel_pa) |-> avs_readdata[3:0] == ($past(pa_in[3:0]) & ~$past(amask)))
      else $error("analog pins not read as zero");

   pb_dir_read_a: assert property (@(posedge clk) disable iff (!resetn)
      (rd_done && sel_pb_dir) |-> avs_readdata[7:0] == $past(pb_dir_q))
      else $error("direction read does not return the register");

   wait_idle_a: assert property (@(posedge clk) disable iff (!resetn)
      !req |=> avs_waitrequest)
      else $error("bus answered without a request");

   readdata_high_a: assert property (@(posedge clk) disable iff (!resetn)
      avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
endmodule

// ### design/gpioc_pkg.sv
// Constants, types and register map of the dual-port GPIO with change flag.
package gpioc_pkg;
   localparam int GPIOC_AW = 5;
   localparam logic [4:0] GPIOC_OFF_PA = 5'h00;
   localparam logic [4:0] GPIOC_OFF_PA_DIR = 5'h04;
   localparam logic [4:0] GPIOC_OFF_ACFG = 5'h08;
   localparam logic [4:0] GPIOC_OFF_PB = 5'h0C;
   localparam logic [4:0] GPIOC_OFF_PB_DIR = 5'h10;
   localparam logic [4:0] GPIOC_OFF_OPT = 5'h14;
   localparam logic [4:0] GPIOC_OFF_ICTL = 5'h18;
   localparam logic [7:0] GPIOC_RST_PA = 8'h00;
   localparam logic [7:0] GPIOC_RST_PA_DIR = 8'h1F;
   localparam logic [7:0] GPIOC_RST_ACFG = 8'h00;
   localparam logic [7:0] GPIOC_RST_PB = 8'h00;
   localparam logic [7:0] GPIOC_RST_PB_DIR = 8'hFF;
   localparam logic [7:0] GPIOC_RST_OPT = 8'hFF;
   localparam logic [7:0] GPIOC_RST_ICTL = 8'h00;
   localparam logic [7:0] GPIOC_PA_MASK = 8'h1F;
   localparam logic [7:0] GPIOC_ACFG_MASK = 8'h07;
   localparam logic [7:0] GPIOC_ICTL_MASK = 8'h09;
   localparam logic [31:0] GPIOC_UNMAPPED = 32'h0000_0000;
   localparam int GPIOC_OD_BIT = 4;
   localparam int GPIOC_PULLUP_N_BIT = 7;
   localparam int GPIOC_FLAG_BIT = 0;
   localparam int GPIOC_CHG_EN_BIT = 3;
   localparam logic [1:0] GPIOC_ACFG_DIGITAL = 2'h3;

   typedef struct packed {
      logic [GPIOC_AW-1:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } gpioc_req_s;

   typedef enum logic [0:0] {
      GPIOC_IDLE = 1'b0,
      GPIOC_DONE = 1'b1
   } gpioc_bus_e;
endpackage

// ### sim/gpioc_pins.sv
// Pin and board model on the far side of the dual-port GPIO.
`timescale 1ns/1ps
module gpioc_pins (
   input wire logic clk,
   input wire logic [4:0] pa_out,
   input wire logic [4:0] pa_oe,
   input wire logic [4:0] ext_a,
   input wire logic [4:0] ext_a_en,
   input wire logic [7:0] pb_out,
   input wire logic [7:0] pb_oe,
   input wire logic [7:0] pb_pullup_en,
   input wire logic [7:0] ext_b,
   input wire logic [7:0] ext_b_en,
   output logic [4:0] pa_in,
   output logic [7:0] pb_in
);
   logic tog_q = 1'b0;
   // A floating pin has no defined level, so it is made to wander every cycle.
   always_ff @(posedge clk) tog_q <= ~tog_q;
   // The open-drain pin only ever pulls low, since its drive value is always 0.
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a_en & ext_a)
      | (~pa_oe & ~ext_a_en & {5{tog_q}});
   // A weak pull-up loses against any board driver.
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b_en & ext_b)
      | (~pb_oe & ~ext_b_en & (pb_pullup_en | {8{tog_q}}));
endmodule

// ### sim/test_gpioc_top.sv
// Self-checking testbench for the dual-port GPIO with change flag.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
   $display("Error at %0t: got %h, expected %h", $time, a, b); end end
module test_gpioc_top;
   import gpioc_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   gpioc_req_s req = '0;
   logic [31:0] rdata;
   logic wait_r;
   logic [4:0] pa_in, pa_out, pa_oe;
   logic [4:0] ext_a = 5'h10;
   logic [4:0] ext_a_en = 5'h10;
   logic [3:0] asel;
   logic tclk, flag, wake;
   logic [7:0] pb_in, pb_out, pb_oe, pb_pu, q;
   logic [7:0] own = '0;
   logic [7:0] pdir = '0;
   logic [7:0] pout = '0;
   logic [7:0] ext_b = '0;
   // The board holds the second port low from the start, so floating inputs cannot
   // raise the change flag before the reset values are read back.
   logic [7:0] ext_b_en = 8'hFF;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   always #20 clk = ~clk;
   gpioc_top i_dut (.clk(clk), .resetn(resetn), .avs_req(req), .avs_readdata(rdata),
      .avs_waitrequest(wait_r), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
      .analog_sel(asel), .timer_clk_in(tclk), .pb_in(pb_in), .pb_out(pb_out),
      .pb_oe(pb_oe), .pb_pullup_en(pb_pu), .periph_own(own), .periph_dir(pdir),
      .periph_out(pout), .port_change_flag(flag), .wake_req(wake));
   gpioc_pins i_pins (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .ext_a(ext_a),
      .ext_a_en(ext_a_en), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup_en(pb_pu),
      .ext_b(ext_b), .ext_b_en(ext_b_en), .pa_in(pa_in), .pb_in(pb_in));
   task automatic conclude;
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         conclude();
      end
   end
   task automatic bus(input logic [4:0] a, input logic w, input logic [15:0] d,
      input logic [3:0] be);
      @(posedge clk);
      req <= '{address: a, read: ~w, write: w, writedata: {16'h0000, d}, byteenable: be};
      @(posedge clk);
      while (wait_r !== 1'b0)
         @(posedge clk);
      q = rdata[7:0];
      req <= '0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(a, 1'b1, {8'hFF, d}, 4'h1);
   endtask
   task automatic rc(input logic [4:0] a, input logic [7:0] e);
      bus(a, 1'b0, 16'h0000, 4'h0);
      `CHK(q, e)
   endtask
   task automatic look;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic set_b(input logic [7:0] v);
      @(posedge clk);
      ext_b <= v;
      look();
   endtask
   task automatic t_reset;
      @(negedge clk);
      `CHK(pa_oe, 5'h00)
      `CHK(asel, 4'hF)
      `CHK(pb_pu, 8'h00)
      rc(GPIOC_OFF_PA_DIR, 8'h1F);
      rc(GPIOC_OFF_ACFG, 8'h00);
      rc(GPIOC_OFF_PB_DIR, 8'hFF);
      rc(GPIOC_OFF_OPT, 8'hFF);
      rc(GPIOC_OFF_ICTL, 8'h00);
      rc(5'h1C, 8'h00);
   endtask
   task automatic t_port_a;
      wr(GPIOC_OFF_PA_DIR, 8'hFF);
      rc(GPIOC_OFF_PA_DIR, 8'h1F);
      wr(GPIOC_OFF_PA_DIR, 8'h00);
      wr(GPIOC_OFF_ACFG, 8'hFE);
      rc(GPIOC_OFF_ACFG, 8'h06);
      wr(GPIOC_OFF_PA, 8'h15);
      look();
      `CHK(pa_oe, 5'h0F)
      `CHK(pa_out, 5'h05)
      `CHK(asel, 4'h0)
      `CHK(tclk, 1'b1)
      rc(GPIOC_OFF_PA, 8'h15);
      wr(GPIOC_OFF_PA, 8'h05);
      look();
      `CHK(pa_oe, 5'h1F)
      `CHK(tclk, 1'b0)
      wr(GPIOC_OFF_ACFG, 8'h00);
      look();
      `CHK(asel, 4'hF)
      `CHK(pa_oe, 5'h1F)
      rc(GPIOC_OFF_PA, 8'h00);
   endtask
   task automatic t_port_b;
      @(posedge clk);
      ext_b_en <= 8'hF0;
      ext_b <= 8'hA0;
      wr(GPIOC_OFF_PB_DIR, 8'hF0);
      // Only the low nibble is masked in; the rest comes from the pin levels.
      bus(GPIOC_OFF_PB, 1'b1, 16'h0F03, 4'h3);
      wr(GPIOC_OFF_PB_DIR, 8'h00);
      look();
      `CHK(pb_oe, 8'hFF)
      `CHK(pb_out, 8'hA3)
      wr(GPIOC_OFF_PB_DIR, 8'h0F);
      wr(GPIOC_OFF_OPT, 8'h7F);
      look();
      `CHK(pb_pu, 8'h0F)
      @(posedge clk);
      own <= 8'h01;
      pout <= 8'h00;
      look();
      `CHK(pb_oe, 8'hF1)
      `CHK(pb_out, 8'hA2)
      `CHK(pb_pu, 8'h0E)
      // Direction is only read back while overridden, never rewritten.
      rc(GPIOC_OFF_PB_DIR, 8'h0F);
      @(posedge clk);
      own <= 8'h00;
      wr(GPIOC_OFF_OPT, 8'hFF);
   endtask
   task automatic t_change;
      wr(GPIOC_OFF_PB_DIR, 8'hFF);
      @(posedge clk);
      ext_b_en <= 8'hFF;
      ext_b <= 8'h00;
      rc(GPIOC_OFF_PB, 8'h00);
      wr(GPIOC_OFF_ICTL, 8'h08);
      set_b(8'h01);
      `CHK(flag, 1'b0)
      // No reads between here and the service, so the change stays visible.
      set_b(8'h11);
      `CHK(flag, 1'b1)
      `CHK(wake, 1'b1)
      wr(GPIOC_OFF_ICTL, 8'h08);
      look();
      `CHK(flag, 1'b1)
      rc(GPIOC_OFF_PB, 8'h11);
      wr(GPIOC_OFF_ICTL, 8'h08);
      look();
      `CHK(flag, 1'b0)
      `CHK(wake, 1'b0)
      // Pin 5 turns output and drives a level unlike its reference; it must be ignored.
      wr(GPIOC_OFF_PB_DIR, 8'hDF);
      look();
      `CHK(flag, 1'b0)
      rc(GPIOC_OFF_ICTL, 8'h08);
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_port_a();
      t_port_b();
      t_change();
      conclude();
   end
endmodule
